// ===== sim/pin_load_model.sv
// External loads on the shared fail pins, with board pull-ups
`timescale 1ns/1ns
module pin_load_model (
    input wire logic blinkFailOe,
    input wire logic blink_fail_output,
    input wire logic pwmFailOe,
    input wire logic pwm_fail_output,
    input wire logic strapLow,
    output logic blinkPinIn,
    output logic pwmPinIn
);
    // Released blink pin rises through its pull-up, never holds the last driven level
    assign blinkPinIn = blinkFailOe ? blink_fail_output : 1'h1;
    // Strap pin stays high while undriven unless an outside strap holds it low for dev mode
    assign pwmPinIn = pwmFailOe ? pwm_fail_output : !strapLow;
endmodule : pin_load_model

// ===== sim/tb_top.sv
// Self-checking bench for the fail output and pin control block
`timescale 1ns/1ns
module tb_top;
    import fail_out_pkg::*;
    localparam int BP = 40;
    localparam int PP = 80;
    localparam int DLY = 2;
    typedef struct {pin_func_t fn; sbc_mode_t md; logic sw; logic [2:0] exp;} row_t;
    logic clk_sys, sys_rst, clkEn, failEvent, failCondPresent, failFlagClear, fail_force_on;
    logic cfgWrite, blinkSwitchOn, pwmSwitchOn, blinkPinIn, pwmPinIn, failureFlag;
    logic static_fail_output, staticFailOe, blink_fail_output, blinkFailOe;
    logic pwm_fail_output, pwmFailOe, blinkWakeEn, pwmWakeEn, blinkPinLevel, pwmPinLevel;
    logic strapValid, strapHigh, strapLow;
    sbc_mode_t sbcMode;
    pin_func_t cfgBlinkFunc, cfgPwmFunc, blinkFunc, pwmFunc;
    duty_t fail_pwm_duty_sel, dutySel;
    int failures, checked;
    int divs[4] = '{DIV_20, DIV_10, DIV_5, DIV_2P5};
    // Expected {oe, driven level, wake} of both shared pins per role and mode
    row_t rows[10] = '{
        '{FUNC_WAKE, MODE_NORMAL, 1'h0, 3'h1}, '{FUNC_WAKE, MODE_RESTART, 1'h0, 3'h1},
        '{FUNC_WAKE, MODE_FAILSAFE, 1'h0, 3'h0}, '{FUNC_WAKE, MODE_SLEEP, 1'h0, 3'h1},
        '{FUNC_LOW_SIDE, MODE_NORMAL, 1'h1, 3'h4}, '{FUNC_LOW_SIDE, MODE_RESTART, 1'h1, 3'h0},
        '{FUNC_LOW_SIDE, MODE_SLEEP, 1'h0, 3'h0}, '{FUNC_HIGH_SIDE, MODE_STOP, 1'h1, 3'h6},
        '{FUNC_HIGH_SIDE, MODE_FAILSAFE, 1'h1, 3'h0}, '{FUNC_OFF, MODE_NORMAL, 1'h1, 3'h0}
    };

    // Short periods keep the run small; 80 keeps the 2.5 percent pulse nonzero
    fail_output_gpio_control #(.BLINK_PERIOD(BP), .PWM_PERIOD(PP)) i_fail_output_gpio_control (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .sbcMode(sbcMode),
        .failEvent(failEvent), .failCondPresent(failCondPresent),
        .failFlagClear(failFlagClear), .fail_force_on(fail_force_on), .cfgWrite(cfgWrite),
        .cfgBlinkFunc(cfgBlinkFunc), .cfgPwmFunc(cfgPwmFunc),
        .fail_pwm_duty_sel(fail_pwm_duty_sel), .blinkSwitchOn(blinkSwitchOn),
        .pwmSwitchOn(pwmSwitchOn), .blinkPinIn(blinkPinIn), .pwmPinIn(pwmPinIn),
        .failureFlag(failureFlag), .static_fail_output(static_fail_output),
        .staticFailOe(staticFailOe), .blink_fail_output(blink_fail_output),
        .blinkFailOe(blinkFailOe), .pwm_fail_output(pwm_fail_output), .pwmFailOe(pwmFailOe),
        .blinkWakeEn(blinkWakeEn), .pwmWakeEn(pwmWakeEn), .blinkPinLevel(blinkPinLevel),
        .pwmPinLevel(pwmPinLevel), .blinkFunc(blinkFunc), .pwmFunc(pwmFunc),
        .dutySel(dutySel), .strapValid(strapValid), .strapHigh(strapHigh)
    );

    pin_load_model i_pin_load_model (
        .blinkFailOe(blinkFailOe), .blink_fail_output(blink_fail_output),
        .pwmFailOe(pwmFailOe), .pwm_fail_output(pwm_fail_output), .strapLow(strapLow),
        .blinkPinIn(blinkPinIn), .pwmPinIn(pwmPinIn)
    );

    // Free-running system clock, 50 ns period
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Inputs change a fixed delay after the edge, so outputs have settled too
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #DLY;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input pin_func_t fb, input pin_func_t fp, input duty_t d);
        cfgBlinkFunc = fb;
        cfgPwmFunc = fp;
        fail_pwm_duty_sel = d;
        cfgWrite = 1'h1;
        step(1);
        cfgWrite = 1'h0;
    endtask : cfg

    // Counts cycles with the chosen pin driven; unknown counts as not driven
    task automatic countHigh(input logic pwm, input int n, output int c);
        c = 0;
        repeat (n) begin
            step(1);
            c += pwm ? int'(pwmFailOe === 1'h1) : int'(blinkFailOe === 1'h1);
        end
    endtask : countHigh

    task automatic doReset();
        sys_rst = 1'h1;
        step(5);
        sys_rst = 1'h0;
    endtask : doReset

    task automatic complete_run();
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial begin
        int c;
        logic [3:0] e;
        failures = 0;
        checked = 0;
        {sys_rst, clkEn, failEvent, failCondPresent, failFlagClear} = 5'h18;
        {fail_force_on, cfgWrite, blinkSwitchOn, pwmSwitchOn, strapLow} = 5'h0;
        sbcMode = MODE_INIT;
        cfgBlinkFunc = FUNC_FAIL;
        cfgPwmFunc = FUNC_FAIL;
        fail_pwm_duty_sel = DUTY_20;
        doReset();
        sbcMode = MODE_NORMAL;
        step(1);
        // Role table: a write outside normal mode must not disturb the role
        foreach (rows[i]) begin
            cfg(rows[i].fn, rows[i].fn, DUTY_20);
            blinkSwitchOn = rows[i].sw;
            pwmSwitchOn = rows[i].sw;
            sbcMode = rows[i].md;
            step(1);
            if (rows[i].md != MODE_NORMAL)
                cfg(FUNC_OFF, FUNC_OFF, DUTY_5);
            step(2);
            chk({blinkFailOe, blinkFailOe & blink_fail_output, blinkWakeEn},
                rows[i].exp);
            chk({pwmFailOe, pwmFailOe & pwm_fail_output, pwmWakeEn},
                rows[i].exp);
            chk({blinkFunc, pwmFunc, dutySel},
                {rows[i].fn, rows[i].fn, DUTY_20});
            sbcMode = MODE_NORMAL;
            // Five edges let the new pin level pass the three-stage synchroniser
            step(5);
            e = {rows[i].sw & (rows[i].fn inside {FUNC_LOW_SIDE, FUNC_HIGH_SIDE}),
                rows[i].fn == FUNC_WAKE, {2{!(rows[i].sw && rows[i].fn == FUNC_LOW_SIDE)}}};
            chk({blinkFailOe, blinkWakeEn, blinkPinLevel, pwmPinLevel}, e);
        end
        // Second reset, then the strap filter in init mode
        sbcMode = MODE_INIT;
        doReset();
        chk({failureFlag, staticFailOe, blinkFailOe, pwmFailOe}, 4'h0);
        chk({strapValid, strapHigh, blinkPinLevel, pwmPinLevel}, 4'h7);
        chk({blinkFunc, pwmFunc, dutySel}, {FUNC_RESET, FUNC_RESET, DUTY_RESET});
        step(STRAP_CYCLES - 40);
        chk(strapValid, 1'h0);
        c = 0;
        while (strapValid !== 1'h1 && c < 100) begin
            step(1);
            c++;
        end
        if (c == 100) begin
            failures++;
            complete_run();
        end
        chk({strapValid, strapHigh}, 2'h3);
        // Failure: flag, all three outputs, waveforms from period start
        sbcMode = MODE_NORMAL;
        failEvent = 1'h1;
        step(1);
        failEvent = 1'h0;
        chk(failureFlag, 1'h1);
        step(1);
        chk({staticFailOe, static_fail_output}, 2'h2);
        countHigh(1'h0, BP / 2, c);
        chk(c, BP / 2);
        countHigh(1'h0, BP, c);
        chk(c, BP / 2);
        countHigh(1'h1, PP, c);
        chk(c, PP / DIV_20);
        sbcMode = MODE_RESTART;
        step(3);
        chk({staticFailOe, failureFlag, blinkFunc}, {2'h3, FUNC_FAIL});
        sbcMode = MODE_NORMAL;
        step(3);
        chk({staticFailOe, blinkFunc}, {1'h1, FUNC_FAIL});
        // A clear while the condition lingers must lose
        failCondPresent = 1'h1;
        failFlagClear = 1'h1;
        step(1);
        failFlagClear = 1'h0;
        step(2);
        chk({failureFlag, staticFailOe}, 2'h3);
        failCondPresent = 1'h0;
        step(1);
        failFlagClear = 1'h1;
        step(1);
        failFlagClear = 1'h0;
        step(3);
        chk({failureFlag, staticFailOe, blinkFailOe, pwmFailOe}, 4'h0);
        // Every duty code under force-on, released again with no failure
        for (int d = 0; d < 4; d++) begin
            cfg(FUNC_FAIL, FUNC_FAIL, duty_t'(d));
            fail_force_on = 1'h1;
            step(3);
            chk({staticFailOe, failureFlag, dutySel}, {2'h2, 2'(d)});
            countHigh(1'h1, PP, c);
            chk(c, PP / divs[d]);
            fail_force_on = 1'h0;
            step(3);
            chk({staticFailOe, blinkFailOe, pwmFailOe}, 3'h0);
        end
        // A strap held low through init selects dev mode only after the full filter time
        strapLow = 1'h1;
        sbcMode = MODE_INIT;
        doReset();
        step(STRAP_CYCLES);
        chk(strapValid, 1'h0);
        c = 0;
        while (strapValid !== 1'h1 && c < 100) begin
            step(1);
            c++;
        end
        if (c == 100) begin
            failures++;
            complete_run();
        end
        chk({strapValid, strapHigh, pwmPinLevel}, 3'h4);
        complete_run();
    end
endmodule : tb_top

// ===== src/fail_out_pkg.sv
// Shared constants and types for the fail output and pin control block
package fail_out_pkg;

    // Device operating modes seen by this block
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } sbc_mode_t;

    // Role of a shared fail/general-purpose pin
    typedef enum logic [2:0] {
        FUNC_FAIL,
        FUNC_OFF,
        FUNC_WAKE,
        FUNC_LOW_SIDE,
        FUNC_HIGH_SIDE
    } pin_func_t;

    // PWM duty selection codes
    typedef enum logic [1:0] {
        DUTY_20,
        DUTY_10,
        DUTY_5,
        DUTY_2P5
    } duty_t;

    // Timing figures in their own units
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BLINK_FREQ_MHZ = 1250;     // Millihertz
    localparam int PWM_FREQ_HZ = 100;
    localparam int STRAP_FILTER_NS = 64_000;

    // Derived cycle counts
    localparam int BLINK_CYCLES = (CLK_HZ / BLINK_FREQ_MHZ) * 1000;
    localparam int PWM_CYCLES = CLK_HZ / PWM_FREQ_HZ;
    localparam int STRAP_CYCLES = STRAP_FILTER_NS / CLK_PERIOD_NS;

    // Duty divisors: high time is period divided by these
    localparam int DIV_20 = 5;
    localparam int DIV_10 = 10;
    localparam int DIV_5 = 20;
    localparam int DIV_2P5 = 40;

    localparam duty_t DUTY_RESET = DUTY_20;
    localparam pin_func_t FUNC_RESET = FUNC_FAIL;

    // High-time cycles of the PWM for a given period and duty code
    function automatic int dutyCycles(input int period, input duty_t sel);
        int div;
        div = DIV_20;
        case (sel)
            DUTY_10: div = DIV_10;
            DUTY_5: div = DIV_5;
            DUTY_2P5: div = DIV_2P5;
            default: div = DIV_20;
        endcase
        return period / div;
    endfunction : dutyCycles

endpackage : fail_out_pkg

// ===== src/fail_output_gpio_control.sv
// Fail outputs, shared pin roles and test strap filter
`timescale 1ns/1ns
module fail_output_gpio_control #(
    parameter int BLINK_PERIOD = fail_out_pkg::BLINK_CYCLES,
    parameter int PWM_PERIOD = fail_out_pkg::PWM_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire fail_out_pkg::sbc_mode_t sbcMode,
    input wire logic failEvent,
    input wire logic failCondPresent,
    input wire logic failFlagClear,
    input wire logic fail_force_on,
    input wire logic cfgWrite,
    input wire fail_out_pkg::pin_func_t cfgBlinkFunc,
    input wire fail_out_pkg::pin_func_t cfgPwmFunc,
    input wire fail_out_pkg::duty_t fail_pwm_duty_sel,
    input wire logic blinkSwitchOn,
    input wire logic pwmSwitchOn,
    input wire logic blinkPinIn,
    input wire logic pwmPinIn,
    output logic failureFlag,
    output logic static_fail_output,
    output logic staticFailOe,
    output logic blink_fail_output,
    output logic blinkFailOe,
    output logic pwm_fail_output,
    output logic pwmFailOe,
    output logic blinkWakeEn,
    output logic pwmWakeEn,
    output logic blinkPinLevel,
    output logic pwmPinLevel,
    output fail_out_pkg::pin_func_t blinkFunc,
    output fail_out_pkg::pin_func_t pwmFunc,
    output fail_out_pkg::duty_t dutySel,
    output logic strapValid,
    output logic strapHigh
);
    import fail_out_pkg::*;

    localparam int SW = $clog2(STRAP_CYCLES + 1);
    localparam logic [SW-1:0] STRAP_DONE = SW'(STRAP_CYCLES);

    logic failActive;
    logic blinkPhase;
    logic pwmPhase;
    logic [2:0] blinkSync;
    logic [2:0] pwmSync;
    logic pwmStable;
    logic [SW-1:0] strapCnt;
    logic isNormal;
    logic isRestart;
    logic isFailsafe;

    assign isNormal = (sbcMode == MODE_NORMAL);
    assign isRestart = (sbcMode == MODE_RESTART);
    assign isFailsafe = (sbcMode == MODE_FAILSAFE);

    // Outputs stay on while the flag, a live failure or the force bit holds
    assign failActive = failureFlag || failCondPresent || fail_force_on;

    // Sticky failure flag; a new failure beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            failureFlag <= 1'b0;
        end else if (clkEn) begin
            if (failEvent || failCondPresent) begin
                failureFlag <= 1'b1;
            end else if (failFlagClear) begin
                failureFlag <= 1'b0;
            end
        end
    end

    // Pin roles and duty change only in normal mode, elsewhere they are frozen
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blinkFunc <= FUNC_RESET;
            pwmFunc <= FUNC_RESET;
            dutySel <= DUTY_RESET;
        end else if (clkEn && cfgWrite && isNormal) begin
            blinkFunc <= cfgBlinkFunc;
            pwmFunc <= cfgPwmFunc;
            dutySel <= fail_pwm_duty_sel;
        end
    end

    fail_wave_gen #(
        .BLINK_PERIOD(BLINK_PERIOD),
        .PWM_PERIOD(PWM_PERIOD)
    ) u_wave (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .active(failActive),
        .dutySel(dutySel),
        .blinkPhase(blinkPhase),
        .pwmPhase(pwmPhase)
    );

    // Pin level synchronisers; only the second and third stages are looked at
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blinkSync <= 3'h7;
            pwmSync <= 3'h7;
        end else if (clkEn) begin
            blinkSync <= {blinkSync[1:0], blinkPinIn};
            pwmSync <= {pwmSync[1:0], pwmPinIn};
        end
    end

    // Accept a pin level change once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blinkPinLevel <= 1'b1;
            pwmPinLevel <= 1'b1;
        end else if (clkEn) begin
            if (blinkSync[1] == blinkSync[2]) begin
                blinkPinLevel <= blinkSync[2];
            end
            if (pwmSync[1] == pwmSync[2]) begin
                pwmPinLevel <= pwmSync[2];
            end
        end
    end

    assign pwmStable = (pwmSync[1] == pwmSync[2]) && (pwmSync[2] == pwmPinLevel);

    // Strap filter runs in init mode only; the pull-up needs the pin undriven
    // then, and a low strap that lasts the full filter time selects dev mode.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strapCnt <= '0;
            strapValid <= 1'b0;
            strapHigh <= 1'b1;
        end else if (clkEn && sbcMode == MODE_INIT && !strapValid) begin
            if (!pwmStable || strapCnt == '0 && pwmPinLevel != strapHigh) begin
                strapCnt <= '0;
                strapHigh <= pwmPinLevel;
            end else if (strapCnt == STRAP_DONE - 1'b1) begin
                strapValid <= 1'b1;
            end else begin
                strapCnt <= strapCnt + 1'b1;
            end
        end
    end

    // Static output always has the fail role and is open drain, active low
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            static_fail_output <= 1'b0;
            staticFailOe <= 1'b0;
        end else if (clkEn) begin
            staticFailOe <= failActive;
        end
    end

    // Blink pin: fail blink, wake input or switch by its frozen role
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blink_fail_output <= 1'b0;
            blinkFailOe <= 1'b0;
            blinkWakeEn <= 1'b0;
        end else if (clkEn) begin
            blink_fail_output <= (blinkFunc == FUNC_HIGH_SIDE);
            blinkWakeEn <= (blinkFunc == FUNC_WAKE) && !isFailsafe;
            case (blinkFunc)
                FUNC_FAIL: blinkFailOe <= blinkPhase;
                FUNC_LOW_SIDE, FUNC_HIGH_SIDE:
                    blinkFailOe <= blinkSwitchOn && !isRestart && !isFailsafe;
                default: blinkFailOe <= 1'b0;
            endcase
        end
    end

    // PWM pin: same roles, and never driven during init so the strap reads
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwm_fail_output <= 1'b0;
            pwmFailOe <= 1'b0;
            pwmWakeEn <= 1'b0;
        end else if (clkEn) begin
            pwm_fail_output <= (pwmFunc == FUNC_HIGH_SIDE);
            pwmWakeEn <= (pwmFunc == FUNC_WAKE) && !isFailsafe;
            if (sbcMode == MODE_INIT) begin
                pwmFailOe <= 1'b0;
            end else begin
                case (pwmFunc)
                    FUNC_FAIL: pwmFailOe <= pwmPhase;
                    FUNC_LOW_SIDE, FUNC_HIGH_SIDE:
                        pwmFailOe <= pwmSwitchOn && !isRestart && !isFailsafe;
                    default: pwmFailOe <= 1'b0;
                endcase
            end
        end
    end

    property p_cfgFixed;
        @(posedge clk_sys) disable iff (sys_rst)
        !isNormal |=> $stable(blinkFunc) && $stable(pwmFunc) && $stable(dutySel);
    endproperty
    a_cfgFixed: assert property (p_cfgFixed) else $error("config not frozen");

    property p_cfgTake;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && cfgWrite && isNormal |=> blinkFunc == $past(cfgBlinkFunc)
            && pwmFunc == $past(cfgPwmFunc);
    endproperty
    a_cfgTake: assert property (p_cfgTake) else $error("config write lost");

    property p_failDrive;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && failEvent ##1 clkEn |=> staticFailOe && failureFlag;
    endproperty
    a_failDrive: assert property (p_failDrive) else $error("fail not signalled");

    property p_wakeOff;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && isFailsafe |=> !blinkWakeEn && !pwmWakeEn;
    endproperty
    a_wakeOff: assert property (p_wakeOff) else $error("wake on in fail-safe");

    property p_switchOff;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && (isRestart || isFailsafe) && pwmFunc inside {FUNC_LOW_SIDE, FUNC_HIGH_SIDE}
            |=> !pwmFailOe;
    endproperty
    a_switchOff: assert property (p_switchOff) else $error("switch on in restart");

    property p_flagHold;
        @(posedge clk_sys) disable iff (sys_rst)
        failureFlag && !(clkEn && failFlagClear) |=> failureFlag;
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag dropped");

    property p_release;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && !failActive |=> !staticFailOe;
    endproperty
    a_release: assert property (p_release) else $error("fail output stuck");

    property p_strapTime;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(strapValid) |-> $past(strapCnt) == STRAP_DONE - 1'b1;
    endproperty
    a_strapTime: assert property (p_strapTime) else $error("strap filter short");

endmodule : fail_output_gpio_control

// ===== src/fail_wave_gen.sv
// Blink and PWM waveform generator for the fail outputs
`timescale 1ns/1ns
module fail_wave_gen #(
    parameter int BLINK_PERIOD = fail_out_pkg::BLINK_CYCLES,
    parameter int PWM_PERIOD = fail_out_pkg::PWM_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic active,
    input wire fail_out_pkg::duty_t dutySel,
    output logic blinkPhase,
    output logic pwmPhase
);
    import fail_out_pkg::*;

    localparam int BW = $clog2(BLINK_PERIOD);
    localparam int PW = $clog2(PWM_PERIOD);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_PERIOD - 1);
    localparam logic [BW-1:0] BLINK_HALF = BW'(BLINK_PERIOD / 2);
    localparam logic [PW-1:0] PWM_LAST = PW'(PWM_PERIOD - 1);

    logic [BW-1:0] blinkCnt;
    logic [PW-1:0] pwmCnt;
    logic [PW-1:0] pwmHigh;

    assign pwmHigh = PW'(dutyCycles(PWM_PERIOD, dutySel));

    // Counters sit at zero while idle so each activation starts a fresh period
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (clkEn && !active)) begin
            blinkCnt <= '0;
            pwmCnt <= '0;
        end else if (clkEn) begin
            blinkCnt <= (blinkCnt == BLINK_LAST) ? '0 : blinkCnt + 1'b1;
            pwmCnt <= (pwmCnt == PWM_LAST) ? '0 : pwmCnt + 1'b1;
        end
    end

    // Phase flags: first half of blink and first duty part of PWM are the on time
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blinkPhase <= 1'b0;
            pwmPhase <= 1'b0;
        end else if (clkEn) begin
            blinkPhase <= active && (blinkCnt < BLINK_HALF);
            pwmPhase <= active && (pwmCnt < pwmHigh);
        end
    end

    property p_restart;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && !active ##1 clkEn && active |-> blinkCnt == '0 && pwmCnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("counters not restarted");

    property p_pwmDuty;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && active && $past(clkEn) && $past(active) && $fell(pwmPhase)
            |-> $past(pwmCnt) == pwmHigh;
    endproperty
    a_pwmDuty: assert property (p_pwmDuty) else $error("pwm high time wrong");

    property p_blinkHalf;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && active && $past(clkEn) && $past(active) && $fell(blinkPhase)
            |-> $past(blinkCnt) == BLINK_HALF;
    endproperty
    a_blinkHalf: assert property (p_blinkHalf) else $error("blink half wrong");

endmodule : fail_wave_gen
